/* File: rfpr_pkg.sv */
package rfpr_pkg;
  // register addresses, seven bits as carried in the command byte
  localparam logic [6:0] ADDR_BUF = 7'h00;
  localparam logic [6:0] ADDR_AMP = 7'h0C;
  localparam logic [6:0] ADDR_PTR = 7'h0D;
  localparam logic [6:0] ADDR_TXB = 7'h0E;
  localparam logic [6:0] ADDR_RXB = 7'h0F;
  localparam logic [6:0] ADDR_LAST = 7'h10;
  localparam logic [6:0] ADDR_MASK = 7'h11;
  localparam logic [6:0] ADDR_FLAGS = 7'h12;

  // reset values; amp reset puts gain step one in bits 7-5
  localparam logic [7:0] RST_AMP = 8'h20;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_TXB = 8'h80;
  localparam logic [7:0] RST_RXB = 8'h00;
  localparam logic [7:0] RST_LAST = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // amplifier field codes
  localparam logic [2:0] GAIN_MAX = 3'h1;
  localparam logic [2:0] GAIN_MIN = 3'h6;
  localparam logic [1:0] HF_BOOST = 2'h3;
  localparam logic [1:0] LF_DEFAULT = 2'h0;

  // command byte layout
  localparam int CMD_WRITE_BIT = 7;

  // event bit positions, shared by flags and mask
  localparam int EV_RX_TIMEOUT = 7;
  localparam int EV_RX_DONE = 6;
  localparam int EV_CRC_ERR = 5;
  localparam int EV_HDR_OK = 4;
  localparam int EV_TX_DONE = 3;
  localparam int EV_SCAN_DONE = 2;
  localparam int EV_HOP_CHANGE = 1;
  localparam int EV_ACT_FOUND = 0;

  // serial framing
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} rfpr_state_e;

  typedef struct packed {
    logic [2:0] gain_step;
    logic [1:0] low_band_amp_current;
    logic reserved_bit;
    logic [1:0] high_band_amp_current;
  } rfpr_amp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rfpr_byte_s;
endpackage

/* File: rfpr_spi_shift.sv */
`timescale 1ns/100ps
module rfpr_spi_shift (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset, high
  input wire logic spi_sclk, // serial clock from host
  input wire logic spi_nss_n, // frame select, low active
  input wire logic spi_mosi, // data from host
  output logic spi_miso_o, // data to host
  output logic spi_miso_oe, // drive enable for data to host
  input wire logic [7:0] tx_byte, // next byte to return
  output rfpr_pkg::rfpr_byte_s rx_evt // received byte, valid one cycle
);
  logic sclk_q;
  logic sclk_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  rfpr_pkg::rfpr_byte_s evt_q;
  rfpr_pkg::rfpr_byte_s evt_d;
  logic rise;
  logic fall;

  // sclk edges; host must hold each phase two clk_sys cycles
  assign rise = spi_sclk && !sclk_q && !spi_nss_n;
  assign fall = !spi_sclk && sclk_q && !spi_nss_n;

  // mode 0: sample on rise, shift out on fall, msb first
  always_comb begin
    sclk_d = spi_sclk;
    rx_d = rx_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    evt_d.valid = 1'b0;
    evt_d.data = evt_q.data;
    if (spi_nss_n) begin
      cnt_d = 3'h0;
    end else if (rise) begin
      rx_d = {rx_q[6:0], spi_mosi};
      cnt_d = cnt_q + 3'h1;
      if (cnt_q == rfpr_pkg::LAST_BIT) begin
        evt_d.valid = 1'b1;
        evt_d.data = {rx_q[6:0], spi_mosi};
      end
    end else if (fall) begin
      // a new byte is fetched only at a byte boundary
      tx_d = (cnt_q == 3'h0) ? tx_byte : {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclk_q <= 1'b0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 3'h0;
      evt_q <= '0;
    end else begin
      sclk_q <= sclk_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      evt_q <= evt_d;
    end
  end

  assign rx_evt = evt_q;
  assign spi_miso_o = tx_q[7];
  assign spi_miso_oe = !spi_nss_n;

  AST_SPI_BYTE: assert property (@(posedge clk_sys) disable iff (srst)
    rise && cnt_q == 3'h7 |=> rx_evt.valid && rx_evt.data[0] == $past(spi_mosi))
    else $error("byte not delivered after eighth edge");
  AST_SPI_QUIET: assert property (@(posedge clk_sys) disable iff (srst)
    spi_nss_n |-> !spi_miso_oe ##1 !rx_evt.valid)
    else $error("serial output active outside a frame");
endmodule

/* File: rfpr_regs.sv */
`timescale 1ns/100ps
// Functional notes
// - gain bits 7-5, codes 1..6 only
// - high-band current 11 gives 150% boost
// - 0x0D buffer pointer, rw, reset zero
// - 0x0E transmit base, rw, reset 0x80
// - 0x0F receive base, rw, reset zero
// - 0x10 last packet start, read only
// - mask bits 7-4 suppress receive events
// - mask bits 3,2 suppress transmit, scan done
// - mask bits 1,0 suppress hop, activity found
// - event flags cleared by writing one
module rfpr_regs #(
  parameter int BUF_DEPTH = 256 // data buffer size in bytes
) (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic srst, // sync reset, high
  input wire logic spi_sclk, // serial clock from host
  input wire logic spi_nss_n, // frame select, low active
  input wire logic spi_mosi, // data from host
  output logic spi_miso_o, // data to host
  output logic spi_miso_oe, // drive enable for data to host
  input wire logic [7:0] event_in, // modem event pulses, flag layout
  input wire logic last_start_valid, // pulse: new packet start address
  input wire logic [7:0] last_start_addr, // packet start address
  output rfpr_pkg::rfpr_amp_s amp_cfg, // amplifier settings
  output logic amp_boost_hf, // high-band boost active
  output logic [7:0] tx_payload_base, // transmit base location
  output logic [7:0] rx_payload_base, // receive base location
  output logic event_irq // interrupt to host, high
);
  rfpr_pkg::rfpr_byte_s rx_evt;
  logic [7:0] rd_data;
  rfpr_pkg::rfpr_state_e st_q;
  rfpr_pkg::rfpr_state_e st_d;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  rfpr_pkg::rfpr_amp_s amp_q;
  rfpr_pkg::rfpr_amp_s amp_d;
  rfpr_pkg::rfpr_amp_s amp_wr;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] txb_q;
  logic [7:0] txb_d;
  logic [7:0] rxb_q;
  logic [7:0] rxb_d;
  logic [7:0] last_q;
  logic [7:0] last_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] clr;
  logic irq_q;
  logic irq_d;
  logic wr_en;
  logic rd_done;
  logic buf_acc;
  logic [7:0] mem [BUF_DEPTH];

  rfpr_spi_shift u_shift (
    .clk_sys(clk_sys),
    .srst(srst),
    .spi_sclk(spi_sclk),
    .spi_nss_n(spi_nss_n),
    .spi_mosi(spi_mosi),
    .spi_miso_o(spi_miso_o),
    .spi_miso_oe(spi_miso_oe),
    .tx_byte(rd_data),
    .rx_evt(rx_evt)
  );

  // byte classification for the current frame
  assign wr_en = rx_evt.valid && st_q == rfpr_pkg::ST_WR;
  assign rd_done = rx_evt.valid && st_q == rfpr_pkg::ST_RD;
  assign buf_acc = (wr_en || rd_done) && addr_q == rfpr_pkg::ADDR_BUF;
  assign amp_wr = rx_evt.data;

  // frame sequencing and address walk
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    if (spi_nss_n) begin
      st_d = rfpr_pkg::ST_CMD;
    end else if (rx_evt.valid) begin
      unique case (st_q)
        rfpr_pkg::ST_CMD: begin
          st_d = rx_evt.data[rfpr_pkg::CMD_WRITE_BIT] ? rfpr_pkg::ST_WR : rfpr_pkg::ST_RD;
          addr_d = rx_evt.data[6:0];
        end
        rfpr_pkg::ST_WR, rfpr_pkg::ST_RD: begin
          // buffer bursts stay on the buffer port, the pointer walks instead
          if (addr_q != rfpr_pkg::ADDR_BUF) begin
            addr_d = addr_q + 7'h01;
          end
        end
        default: begin
          st_d = rfpr_pkg::ST_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= rfpr_pkg::ST_CMD;
      addr_q <= 7'h00;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
    end
  end

  // register writes and hardware updates
  always_comb begin
    amp_d = amp_q;
    ptr_d = ptr_q;
    txb_d = txb_q;
    rxb_d = rxb_q;
    last_d = last_q;
    mask_d = mask_q;
    clr = 8'h00;
    if (buf_acc) begin
      ptr_d = ptr_q + 8'h01;
    end
    if (wr_en) begin
      unique case (addr_q)
        rfpr_pkg::ADDR_AMP: begin
          amp_d = amp_wr;
          // unused gain codes are dropped so the front end never sees them
          if (amp_wr.gain_step < rfpr_pkg::GAIN_MAX || amp_wr.gain_step > rfpr_pkg::GAIN_MIN) begin
            amp_d.gain_step = amp_q.gain_step;
          end
        end
        rfpr_pkg::ADDR_PTR: ptr_d = rx_evt.data;
        rfpr_pkg::ADDR_TXB: txb_d = rx_evt.data;
        rfpr_pkg::ADDR_RXB: rxb_d = rx_evt.data;
        rfpr_pkg::ADDR_MASK: mask_d = rx_evt.data;
        rfpr_pkg::ADDR_FLAGS: clr = rx_evt.data;
        default: begin
          // read-only and unmapped locations ignore writes
        end
      endcase
    end
    if (last_start_valid) begin
      last_d = last_start_addr;
    end
    // set beats clear so an event landing on the clear write survives
    flags_d = (flags_q & ~clr) | event_in;
    // flags keep masked events; only the interrupt is gated
    irq_d = |(flags_d & ~mask_d);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      amp_q <= rfpr_pkg::RST_AMP;
      ptr_q <= rfpr_pkg::RST_PTR;
      txb_q <= rfpr_pkg::RST_TXB;
      rxb_q <= rfpr_pkg::RST_RXB;
      last_q <= rfpr_pkg::RST_LAST;
      mask_q <= rfpr_pkg::RST_MASK;
      flags_q <= rfpr_pkg::RST_FLAGS;
      irq_q <= 1'b0;
    end else begin
      amp_q <= amp_d;
      ptr_q <= ptr_d;
      txb_q <= txb_d;
      rxb_q <= rxb_d;
      last_q <= last_d;
      mask_q <= mask_d;
      flags_q <= flags_d;
      irq_q <= irq_d;
    end
  end

  // data buffer; no reset, contents are undefined at power up
  always_ff @(posedge clk_sys) begin
    if (buf_acc && wr_en) begin
      mem[ptr_q] <= rx_evt.data;
    end
  end

  // read data for the next serial byte, loaded at the byte boundary
  always_comb begin
    unique case (addr_q)
      rfpr_pkg::ADDR_BUF: rd_data = mem[ptr_q];
      rfpr_pkg::ADDR_AMP: rd_data = amp_q;
      rfpr_pkg::ADDR_PTR: rd_data = ptr_q;
      rfpr_pkg::ADDR_TXB: rd_data = txb_q;
      rfpr_pkg::ADDR_RXB: rd_data = rxb_q;
      rfpr_pkg::ADDR_LAST: rd_data = last_q;
      rfpr_pkg::ADDR_MASK: rd_data = mask_q;
      rfpr_pkg::ADDR_FLAGS: rd_data = flags_q;
      default: rd_data = 8'h00;
    endcase
  end

  assign amp_cfg = amp_q;
  assign amp_boost_hf = amp_q.high_band_amp_current == rfpr_pkg::HF_BOOST;
  assign tx_payload_base = txb_q;
  assign rx_payload_base = rxb_q;
  assign event_irq = irq_q;

  AST_GAIN_LEGAL: assert property (@(posedge clk_sys) disable iff (srst)
    wr_en && addr_q == rfpr_pkg::ADDR_AMP |=> amp_q.gain_step inside {[3'h1:3'h6]})
    else $error("gain step left the legal range");
  AST_HF_BOOST: assert property (@(posedge clk_sys) disable iff (srst)
    wr_en && addr_q == rfpr_pkg::ADDR_AMP && rx_evt.data[1:0] == 2'h3 |=> amp_boost_hf)
    else $error("boost not raised by code 11");
  AST_PTR_INC: assert property (@(posedge clk_sys) disable iff (srst)
    buf_acc |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance on buffer access");
  AST_TXB_RST: assert property (@(posedge clk_sys)
    srst ##1 !srst |-> tx_payload_base == 8'h80 && rx_payload_base == 8'h00)
    else $error("base reset value wrong");
  AST_RXB_WR: assert property (@(posedge clk_sys) disable iff (srst)
    wr_en && addr_q == rfpr_pkg::ADDR_RXB |=> rx_payload_base == $past(rx_evt.data))
    else $error("receive base write lost");
  AST_LAST_RO: assert property (@(posedge clk_sys) disable iff (srst)
    wr_en && addr_q == rfpr_pkg::ADDR_LAST && !last_start_valid |=> $stable(last_q))
    else $error("read-only packet start was written");
  AST_IRQ_MASKED: assert property (@(posedge clk_sys) disable iff (srst)
    mask_q == 8'hFF && !(wr_en && addr_q == rfpr_pkg::ADDR_MASK) |=> !event_irq)
    else $error("interrupt raised with all events masked");
  AST_IRQ_TX: assert property (@(posedge clk_sys) disable iff (srst)
    event_in[3] && !mask_q[3] && !(wr_en && addr_q == rfpr_pkg::ADDR_MASK) |=> event_irq && flags_q[3])
    else $error("unmasked transmit event gave no interrupt");
  AST_FLAG_SET_WINS: assert property (@(posedge clk_sys) disable iff (srst)
    event_in[1] |=> flags_q[1])
    else $error("event flag lost against a clear");
  AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (srst)
    event_irq |-> $past(|(flags_d & ~mask_d)))
    else $error("interrupt without an unmasked flag");
endmodule

/* File: rfpr_host_model.sv */
`timescale 1ns/100ps
// host side serial master, mode 0, msb first; phase sets the pace
module rfpr_host_model (
  input wire logic clk_sys, // system clock
  output logic spi_sclk, // serial clock, idle low
  output logic spi_nss_n, // frame select, low active
  output logic spi_mosi, // data to device
  input wire logic spi_miso_o, // data from device
  input wire logic spi_miso_oe // device drive enable
);
  int phase = 2; // cycles per sclk phase, two is the fastest legal pace
  initial begin
    spi_sclk = 1'b0;
    spi_nss_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // data launched while low, sampled at the rise; undriven line reads unknown
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      wait_cyc(phase);
      spi_sclk = 1'b1;
      rx[i] = spi_miso_oe ? spi_miso_o : 1'bx;
      wait_cyc(phase);
      spi_sclk = 1'b0;
    end
  endtask
  // command byte then one data byte
  task automatic frame(input logic wr, input logic [6:0] addr, input logic [7:0] din, output logic [7:0] dout);
    logic [7:0] unused;
    if (wr && addr == rfpr_pkg::ADDR_AMP) din[4:3] = rfpr_pkg::LF_DEFAULT;
    wait_cyc(1);
    spi_nss_n = 1'b0;
    wait_cyc(2); // select leads the first rise
    shift_byte({wr, addr}, unused);
    shift_byte(din, dout);
    wait_cyc(phase);
    spi_nss_n = 1'b1;
    spi_mosi = ~spi_mosi; // no stale data between frames
    wait_cyc(2);
  endtask
endmodule

/* File: rfpr_regs_tb.sv */
`timescale 1ns/100ps
module rfpr_regs_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic spi_sclk, spi_nss_n, spi_mosi, spi_miso_o, spi_miso_oe;
  logic [7:0] event_in = 8'h00;
  logic last_start_valid = 1'b0;
  logic [7:0] last_start_addr = 8'h00;
  rfpr_pkg::rfpr_amp_s amp_cfg;
  logic amp_boost_hf, event_irq;
  logic [7:0] tx_payload_base, rx_payload_base;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  rfpr_regs u_rfpr_regs (
    .clk_sys(clk_sys), .srst(srst), .spi_sclk(spi_sclk), .spi_nss_n(spi_nss_n),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .event_in(event_in), .last_start_valid(last_start_valid), .last_start_addr(last_start_addr),
    .amp_cfg(amp_cfg), .amp_boost_hf(amp_boost_hf), .tx_payload_base(tx_payload_base),
    .rx_payload_base(rx_payload_base), .event_irq(event_irq)
  );
  rfpr_host_model u_rfpr_host_model (
    .clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_nss_n(spi_nss_n),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe)
  );
  task automatic tally_and_finish;
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // the whole run needs a few thousand cycles; a hang ends here
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_rfpr_host_model.frame(1'b1, a, d, unused);
  endtask
  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_rfpr_host_model.frame(1'b0, a, 8'h00, got);
    chk(what, exp, got);
  endtask
  // one-cycle event pulse, then time for flag and interrupt to settle
  task automatic pulse(input logic [7:0] ev);
    @(negedge clk_sys);
    event_in = ev;
    @(negedge clk_sys);
    event_in = 8'h00;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic test_reset_values;
    rd_chk("amp", rfpr_pkg::ADDR_AMP, rfpr_pkg::RST_AMP);
    rd_chk("ptr", rfpr_pkg::ADDR_PTR, 8'h00);
    rd_chk("txb", rfpr_pkg::ADDR_TXB, 8'h80);
    rd_chk("rxb", rfpr_pkg::ADDR_RXB, 8'h00);
    rd_chk("mask", rfpr_pkg::ADDR_MASK, 8'h00);
    rd_chk("unmapped", 7'h13, 8'h00);
    chk("txb out", 8'h80, tx_payload_base);
  endtask
  // writes at a slow pace, read back at the fastest
  task automatic test_pointers;
    u_rfpr_host_model.phase = 4;
    wr(rfpr_pkg::ADDR_PTR, 8'hA5);
    wr(rfpr_pkg::ADDR_TXB, 8'h5A);
    wr(rfpr_pkg::ADDR_RXB, 8'hFF);
    u_rfpr_host_model.phase = 2;
    rd_chk("ptr", rfpr_pkg::ADDR_PTR, 8'hA5);
    rd_chk("txb", rfpr_pkg::ADDR_TXB, 8'h5A);
    rd_chk("rxb", rfpr_pkg::ADDR_RXB, 8'hFF);
    chk("txb out", 8'h5A, tx_payload_base);
    chk("rxb out", 8'hFF, rx_payload_base);
  endtask
  // one byte into the buffer and back; every buffer access walks the pointer
  task automatic test_buffer;
    wr(rfpr_pkg::ADDR_PTR, 8'h10);
    wr(rfpr_pkg::ADDR_BUF, 8'h3C);
    rd_chk("ptr walk wr", rfpr_pkg::ADDR_PTR, 8'h11);
    wr(rfpr_pkg::ADDR_PTR, 8'h10);
    rd_chk("buffer", rfpr_pkg::ADDR_BUF, 8'h3C);
    rd_chk("ptr walk rd", rfpr_pkg::ADDR_PTR, 8'h11);
  endtask
  // host writes must not disturb the captured start address
  task automatic test_last_start;
    @(negedge clk_sys);
    last_start_addr = 8'h3C;
    last_start_valid = 1'b1;
    @(negedge clk_sys);
    last_start_valid = 1'b0;
    last_start_addr = 8'hC3;
    wr(rfpr_pkg::ADDR_LAST, 8'hFF);
    rd_chk("last", rfpr_pkg::ADDR_LAST, 8'h3C);
  endtask
  // unused gain codes keep the old gain, other fields still land
  task automatic test_amp;
    wr(rfpr_pkg::ADDR_AMP, 8'hC3);
    chk("amp", 8'hC3, amp_cfg);
    chk("boost", 8'h01, {7'h00, amp_boost_hf});
    wr(rfpr_pkg::ADDR_AMP, 8'hE0);
    chk("amp", 8'hC0, amp_cfg);
    chk("boost", 8'h00, {7'h00, amp_boost_hf});
    wr(rfpr_pkg::ADDR_AMP, 8'h20);
    wr(rfpr_pkg::ADDR_AMP, 8'h03);
    chk("amp", 8'h23, amp_cfg);
  endtask
  // each mask bit hides its own event only; writing ones clears flags
  task automatic test_events;
    logic [7:0] bit_i;
    logic [7:0] bit_n;
    for (int i = 0; i < 8; i++) begin
      bit_i = 8'h01 << i;
      bit_n = 8'h01 << ((i + 1) % 8);
      wr(rfpr_pkg::ADDR_MASK, bit_i);
      pulse(bit_i);
      chk("irq masked", 8'h00, {7'h00, event_irq});
      rd_chk("flags", rfpr_pkg::ADDR_FLAGS, bit_i);
      pulse(bit_n);
      chk("irq open", 8'h01, {7'h00, event_irq});
      wr(rfpr_pkg::ADDR_FLAGS, bit_i | bit_n);
      rd_chk("flags", rfpr_pkg::ADDR_FLAGS, 8'h00);
      chk("irq clear", 8'h00, {7'h00, event_irq});
    end
    rd_chk("mask", rfpr_pkg::ADDR_MASK, 8'h80);
    // all events at once with every bit masked: flags record, no interrupt
    wr(rfpr_pkg::ADDR_MASK, 8'hFF);
    pulse(8'hFF);
    chk("irq all masked", 8'h00, {7'h00, event_irq});
    rd_chk("flags all", rfpr_pkg::ADDR_FLAGS, 8'hFF);
    wr(rfpr_pkg::ADDR_FLAGS, 8'hFF);
    rd_chk("flags cleared", rfpr_pkg::ADDR_FLAGS, 8'h00);
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    test_reset_values();
    test_pointers();
    test_buffer();
    test_last_start();
    test_amp();
    test_events();
    tally_and_finish();
  end
endmodule
